// ---- rtl/nfc_map.svh ----
// constants for the nand flash host controller: timing counts, commands, limits
// assumes a 200 MHz clock; all counts are in clk_i cycles
// ************************************************************
// Operation
// R1: device latches port byte as command on write rise while command latch high.
// R2: device latches port byte as address on write rise while address latch high.
// R3: with both latches low, write strobe carries data bytes.
// R4: one eight-bit two-way port carries commands, addresses and data.
// R5: chip select high while ready puts device in standby.
// R6: chip select is ignored while device is busy.
// R7: read strobe fall gives next byte within 20 ns, column advances.
// R8: long read high time: outputs float on rise, 22 ns hold.
// R9: short read high time: outputs stay driven, 5 ns hold after fall.
// R10: extended output floats on latch rise, select rise or write fall.
// R11: write protect low blocks program and erase.
// R12: array to page register load finishes within 25 us while busy.
// R13: reset returns ready within 6, 6, 10 or 500 us.
// R14: host performs at most 4 partial programs per page before erase.
// R15: host waits 20 ns after ready before read strobe falls.
// R16: host never drives data while device drives read data.
// R17: program data column runs from zero to 2111.
// R18: ready_busy_n is low during program, erase and array read.
// R19: address is four latch cycles: two column then two page.
// R20: array read is 00h, address, then 30h.
// R21: program starts when confirm 10h is latched.
// R22: host samples ready_busy_n before commands other than status or reset.
// R23: host asserts one latch at a time, none during data.
// ************************************************************
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH

`define NFC_CLK_MHZ 200
// strobe phase lengths in ns, rounded up to cycles
`define NFC_T_PHASE_NS 15
`define NFC_PHASE_CYC ((`NFC_T_PHASE_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_T_READY_GAP_NS 20
`define NFC_READY_GAP_CYC ((`NFC_T_READY_GAP_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_T_REA_NS 20
`define NFC_REA_CYC ((`NFC_T_REA_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_T_WHR_NS 60
`define NFC_WHR_CYC ((`NFC_T_WHR_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_T_WB_NS 100
`define NFC_WB_CYC ((`NFC_T_WB_NS * `NFC_CLK_MHZ + 999) / 1000)
// busy timeout: worst reset time 500 us
`define NFC_T_BUSY_MAX_US 500
`define NFC_BUSY_MAX_CYC (`NFC_T_BUSY_MAX_US * `NFC_CLK_MHZ)
`define NFC_LAST_COLUMN 12'h083F
`define NFC_MAX_PARTIAL 3'h4
`define NFC_CMD_READ 8'h00
`define NFC_CMD_READ_GO 8'h30
`define NFC_CMD_PROG 8'h80
`define NFC_CMD_PROG_GO 8'h10
`define NFC_CMD_ERASE 8'h60
`define NFC_CMD_ERASE_GO 8'hD0
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_RESET 8'hFF

`endif

// ---- rtl/nfc_pkg.sv ----
// types for the nand flash host controller
// assumes nfc_map.svh for numeric constants
package nfc_pkg;
    // kind of one port cycle asked by the user
    typedef enum logic [2:0] {
        NFC_OP_CMD,
        NFC_OP_ADDR,
        NFC_OP_WDATA,
        NFC_OP_RDATA,
        NFC_OP_WAIT
    } nfc_op_t;

    // one request: kind plus byte
    typedef struct packed {
        nfc_op_t op;
        logic [7:0] data;
    } nfc_req_t;

    // pins driven toward the device
    typedef struct packed {
        logic chip_sel_n;
        logic cmd_latch;
        logic addr_latch;
        logic write_strobe_n;
        logic read_strobe_n;
        logic write_prot_n;
    } nfc_pins_t;
endpackage

// ---- rtl/nfc_host.sv ----
// nand flash host port sequencer: turns user requests into pin cycles
// and keeps read bytes in a two-entry buffer toward the user
// assumes device pins are sampled synchronously to clk_i, one device
// assumes the user orders commands, addresses and waits itself
`timescale 1ns/1ps
`include "nfc_map.svh"

module nfc_host #(
    parameter int BUSY_MAX_CYC = `NFC_BUSY_MAX_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // user request side
    input wire nfc_pkg::nfc_req_t req_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic write_prot_n_i,
    // user read data side
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    // status
    output logic busy_timeout_o,
    output logic prog_refused_o,
    // device pins
    output nfc_pkg::nfc_pins_t pins_o,
    input wire logic [7:0] shared_byte_port_i,
    output logic [7:0] shared_byte_port_o,
    output logic shared_byte_port_oe_n_o,
    input wire logic ready_busy_n_i
);
    // ************************************************************
    // state and working registers
    // ************************************************************
    // sequencer phases: setup, strobe low, strobe high, busy waits, gap
    typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_WAITB, ST_WAITR, ST_GAP} nfc_state_t;
    nfc_state_t state_reg, state_next;
    nfc_pkg::nfc_req_t cur_reg;
    logic [31:0] cnt_reg;
    logic [7:0] out_reg;
    logic oe_n_reg;
    nfc_pkg::nfc_pins_t pins_reg;
    logic [11:0] col_reg;
    logic [1:0] addr_idx_reg;
    logic [2:0] partial_reg;
    // status flags toward the user
    logic timeout_reg;
    logic refused_reg;
    // two-entry read buffer
    logic [7:0] buf_mem [0:1];
    logic [1:0] buf_cnt_reg;
    logic buf_wp_reg;
    logic buf_rp_reg;

    // ************************************************************
    // request decode
    // ************************************************************
    // kind of the transfer in flight
    wire is_cmd = cur_reg.op == nfc_pkg::NFC_OP_CMD;
    wire is_addr = cur_reg.op == nfc_pkg::NFC_OP_ADDR;
    wire is_rd = cur_reg.op == nfc_pkg::NFC_OP_RDATA;
    wire is_wr = cur_reg.op == nfc_pkg::NFC_OP_WDATA;
    // byte taken 20 ns after the strobe rises, still inside the output hold
    wire buf_full = buf_cnt_reg == 2'd2;
    wire buf_push = state_reg == ST_HIGH && is_rd && cnt_reg == 32'd0;
    wire buf_pop = rd_valid_o && rd_ready_i;
    // a phase ends when its down counter reaches zero
    wire phase_done = cnt_reg == 32'd0;
    // write protect refuses both confirms; the partial limit refuses only
    // program, so an erase with write protect high can always clear the limit again
    wire prog_block = partial_reg == `NFC_MAX_PARTIAL; // R14
    wire is_prog_go = req_i.op == nfc_pkg::NFC_OP_CMD && req_i.data == `NFC_CMD_PROG_GO;
    wire is_erase_go = req_i.op == nfc_pkg::NFC_OP_CMD && req_i.data == `NFC_CMD_ERASE_GO;
    wire refuse = (is_prog_go && (prog_block || !write_prot_n_i)) // R11 R14
        || (is_erase_go && !write_prot_n_i); // R11
    // stall reads until a buffer slot is free so no word is lost
    wire start_ok = !(req_i.op == nfc_pkg::NFC_OP_RDATA && buf_full);

    // ************************************************************
    // outputs
    // ************************************************************
    // handshakes are combinational, pins and data come from flip-flops
    assign req_ready_o = state_reg == ST_IDLE && start_ok;
    assign rd_valid_o = buf_cnt_reg != 2'd0;
    assign rd_data_o = buf_mem[buf_rp_reg];
    assign pins_o = pins_reg;
    assign shared_byte_port_o = out_reg;
    assign shared_byte_port_oe_n_o = oe_n_reg;
    assign busy_timeout_o = timeout_reg;
    assign prog_refused_o = refused_reg;

    // ************************************************************
    // pin sequencer
    // ************************************************************
    // next state of the pin sequencer
    always_comb begin
        // hold the state unless the current phase has ended
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (req_valid_i && start_ok && !refuse) state_next = ST_SETUP;
            ST_SETUP: if (phase_done) state_next = ST_LOW;
            ST_LOW: if (phase_done) state_next = ST_HIGH;
            ST_HIGH: if (phase_done) state_next = ST_GAP;
            ST_WAITB: if (phase_done) state_next = ST_WAITR;
            ST_WAITR: if (ready_busy_n_i || phase_done) state_next = ST_GAP; // R18 R22
            ST_GAP: if (phase_done) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_IDLE;
            cur_reg <= '{op: nfc_pkg::NFC_OP_WAIT, data: 8'h00};
            cnt_reg <= 32'd0;
            out_reg <= 8'h00;
            oe_n_reg <= 1'b1;
            pins_reg <= '{chip_sel_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0,
                write_strobe_n: 1'b1, read_strobe_n: 1'b1, write_prot_n: 1'b0};
            col_reg <= 12'h000;
            addr_idx_reg <= 2'd0;
            partial_reg <= 3'd0;
            timeout_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // every phase counts down; a load below overrides the decrement
            cnt_reg <= phase_done ? 32'd0 : cnt_reg - 32'd1;
            // refusal is a one-cycle pulse; the refused request is consumed
            refused_reg <= state_reg == ST_IDLE && req_valid_i && refuse;
            // write protect pin follows the input one cycle later
            pins_reg.write_prot_n <= write_prot_n_i; // R11
            case (state_reg)
                ST_IDLE: if (req_valid_i && start_ok && !refuse) begin
                    cur_reg <= req_i;
                    pins_reg.chip_sel_n <= 1'b0;
                    // one latch at a time, none for data
                    pins_reg.cmd_latch <= req_i.op == nfc_pkg::NFC_OP_CMD; // R1 R23
                    pins_reg.addr_latch <= req_i.op == nfc_pkg::NFC_OP_ADDR; // R2 R23
                    out_reg <= req_i.data;
                    // drive only for writes, never while device reads out
                    oe_n_reg <= !(req_i.op inside {nfc_pkg::NFC_OP_CMD,
                        nfc_pkg::NFC_OP_ADDR, nfc_pkg::NFC_OP_WDATA}); // R4 R16
                    cnt_reg <= (req_i.op == nfc_pkg::NFC_OP_RDATA)
                        ? 32'(`NFC_READY_GAP_CYC) : 32'(`NFC_PHASE_CYC); // R15
                    // a wait skips the strobe phases and watches ready_busy_n
                    if (req_i.op == nfc_pkg::NFC_OP_WAIT) begin
                        state_reg <= ST_WAITB;
                        cnt_reg <= 32'(`NFC_WB_CYC);
                    end
                end
                // the strobe falls once setup has passed
                ST_SETUP: if (phase_done) begin
                    if (is_rd) pins_reg.read_strobe_n <= 1'b0; // R7
                    else pins_reg.write_strobe_n <= 1'b0; // R3
                    cnt_reg <= is_rd ? 32'(`NFC_REA_CYC) : 32'(`NFC_PHASE_CYC);
                end
                ST_LOW: if (phase_done) begin
                    pins_reg.read_strobe_n <= 1'b1;
                    pins_reg.write_strobe_n <= 1'b1; // latch edge for R1 R2
                    cnt_reg <= 32'(`NFC_PHASE_CYC);
                    if (is_addr) begin
                        // two column cycles then two page cycles
                        if (addr_idx_reg == 2'd0) col_reg[7:0] <= cur_reg.data; // R19
                        if (addr_idx_reg == 2'd1) col_reg[11:8] <= cur_reg.data[3:0]; // R19
                        addr_idx_reg <= addr_idx_reg + 2'd1;
                    end
                    if (is_rd || is_wr)
                        col_reg <= (col_reg == `NFC_LAST_COLUMN) ? 12'h000 : col_reg + 12'd1; // R17
                end
                // latches drop and the port is released once the hold has passed
                ST_HIGH: if (phase_done) begin
                    pins_reg.cmd_latch <= 1'b0;
                    pins_reg.addr_latch <= 1'b0;
                    oe_n_reg <= 1'b1;
                    cnt_reg <= is_rd ? 32'(`NFC_PHASE_CYC) : 32'(`NFC_WHR_CYC);
                    if (is_cmd) begin
                        addr_idx_reg <= 2'd0;
                        if (cur_reg.data == `NFC_CMD_PROG_GO)
                            partial_reg <= partial_reg + 3'd1; // R14 R21
                        if (cur_reg.data == `NFC_CMD_ERASE_GO) partial_reg <= 3'd0;
                    end
                end
                // a device stuck busy ends the wait after BUSY_MAX_CYC with the flag set
                ST_WAITB: if (phase_done) begin
                    cnt_reg <= BUSY_MAX_CYC[31:0]; // R12 R13
                    timeout_reg <= 1'b0;
                end
                // ready ends the wait early, then the ready-to-read gap starts
                ST_WAITR: begin
                    if (!ready_busy_n_i && phase_done) timeout_reg <= 1'b1;
                    if (ready_busy_n_i || phase_done) cnt_reg <= 32'(`NFC_READY_GAP_CYC); // R15
                end
                // chip select rises only after the gap, letting the device idle
                ST_GAP: if (phase_done) pins_reg.chip_sel_n <= 1'b1; // R5
                default: ;
            endcase
        end
    end

    // ************************************************************
    // read buffer
    // ************************************************************
    // read buffer: byte sampled at end of strobe high phase
    always_ff @(posedge clk_i) begin
        if (buf_push) buf_mem[buf_wp_reg] <= shared_byte_port_i; // R8 R9
    end

    // pointers and fill count; a push and a pop in one cycle keep the count
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            buf_cnt_reg <= 2'd0;
            buf_wp_reg <= 1'b0;
            buf_rp_reg <= 1'b0;
        end else begin
            if (buf_push) buf_wp_reg <= !buf_wp_reg;
            if (buf_pop) buf_rp_reg <= !buf_rp_reg;
            buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end
endmodule // nfc_host

// ---- testbench/nfc_host_monitor.sv ----
// checker for the nand flash host port sequencer
// assumes it is bound onto nfc_host, single clock domain
`timescale 1ns/1ps

module nfc_host_monitor #(
    parameter int BUSY_MAX_CYC = 200
) (
    // clock, reset, user side
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire nfc_pkg::nfc_req_t req_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic write_prot_n_i,
    input wire logic rd_valid_o,
    input wire logic rd_ready_i,
    input wire logic busy_timeout_o,
    input wire logic prog_refused_o,
    // device pins
    input wire nfc_pkg::nfc_pins_t pins_o,
    input wire logic [7:0] shared_byte_port_o,
    input wire logic shared_byte_port_oe_n_o,
    input wire logic ready_busy_n_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // a program confirm taken from the user
    wire prog_go = req_valid_i && req_ready_o && req_i.op == nfc_pkg::NFC_OP_CMD
        && req_i.data == 8'h10;
    a_one_latch: assert property (!(pins_o.cmd_latch && pins_o.addr_latch))
        else $error("both latch strobes high");
    a_wr_under_cs: assert property (!pins_o.write_strobe_n |-> !pins_o.chip_sel_n)
        else $error("write strobe without chip select");
    a_wr_drives: assert property ($rose(pins_o.write_strobe_n) |->
        !shared_byte_port_oe_n_o && $stable(shared_byte_port_o))
        else $error("port not held at write rise");
    a_rd_no_drive: assert property (!pins_o.read_strobe_n |->
        shared_byte_port_oe_n_o && !pins_o.cmd_latch && !pins_o.addr_latch)
        else $error("host drives or latches during read");
    a_read_ready: assert property ($fell(pins_o.read_strobe_n) |->
        $past(ready_busy_n_i) && $past(ready_busy_n_i, 4))
        else $error("read strobe too soon after ready");
    a_rd_low_width: assert property ($fell(pins_o.read_strobe_n) |->
        !pins_o.read_strobe_n [*3])
        else $error("read strobe low too short");
    a_wp_follows: assert property ($past(reset_n_i) |->
        pins_o.write_prot_n == $past(write_prot_n_i))
        else $error("write protect pin not following input");
    a_wp_refuse: assert property (prog_go && !write_prot_n_i |-> ##[1:4] prog_refused_o)
        else $error("protected confirm not refused");
    c_refused: cover property (prog_refused_o);
    c_timeout: cover property ($rose(busy_timeout_o));
    c_stall: cover property (rd_valid_o && !rd_ready_i);
endmodule // nfc_host_monitor

bind nfc_host nfc_host_monitor #(.BUSY_MAX_CYC(BUSY_MAX_CYC)) u_mon (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .write_prot_n_i(write_prot_n_i), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .busy_timeout_o(busy_timeout_o),
    .prog_refused_o(prog_refused_o), .pins_o(pins_o), .shared_byte_port_o(shared_byte_port_o),
    .shared_byte_port_oe_n_o(shared_byte_port_oe_n_o), .ready_busy_n_i(ready_busy_n_i));

// ---- testbench/nfc_flash_model.sv ----
// behavioural nand flash device facing the host port
// assumes pins come from nfc_host; delays in ns
`timescale 1ns/1ps

module nfc_flash_model #(
    parameter int LOAD_NS = 401
) (
    // pins from the host, stuck-busy control from the bench
    input wire nfc_pkg::nfc_pins_t pins_i,
    input wire logic [7:0] host_d_i,
    input wire logic host_oe_n_i,
    input wire logic stuck_i,
    // resolved port and status
    output logic [7:0] bus_o,
    output logic ready_busy_n_o,
    output logic [3:0] prog_cnt_o
);
    logic [7:0] mem [256];
    logic [7:0] col = 0;
    logic [7:0] dout = 0;
    logic rb = 1;
    logic drv = 0;
    logic standby = 0;
    int acnt = 0;
    // page register preset, only 256 columns kept
    initial begin
        prog_cnt_o = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    end
    // released port shows the inverse of its last value
    assign bus_o = !host_oe_n_i ? host_d_i : drv ? dout : ~dout;
    assign ready_busy_n_o = rb && !stuck_i;
    // byte capture on write rise; busy blocks further capture
    // a deselected device ignores the strobe, as at the reset edge
    always @(posedge pins_i.write_strobe_n) if (!pins_i.chip_sel_n) begin
        dout = host_d_i;
        if (pins_i.cmd_latch) begin
            acnt = 0;
            if (host_d_i == 8'h10 && pins_i.write_prot_n) prog_cnt_o++;
            if (host_d_i inside {8'h30, 8'h10, 8'hFF}) begin
                rb = 0;
                #(LOAD_NS) rb = 1;
            end
        end else if (pins_i.addr_latch) begin
            if (acnt == 0) col = host_d_i;
            acnt++;
        end else begin
            mem[col] = host_d_i;
            col++;
        end
    end
    // serial read: byte after access delay, column advances
    always @(negedge pins_i.read_strobe_n) begin
        if (rb && !pins_i.chip_sel_n) begin
            #4 dout = mem[col];
            drv = 1;
            col++;
        end
    end
    always @(posedge pins_i.read_strobe_n) begin
        #22 drv = 0;
    end
    always @(posedge pins_i.chip_sel_n or posedge pins_i.cmd_latch or
            posedge pins_i.addr_latch or negedge pins_i.write_strobe_n) begin
        drv = 0;
        standby = rb && pins_i.chip_sel_n;
    end
endmodule // nfc_flash_model

// ---- testbench/tb_nfc_host.sv ----
// self-checking bench for the nand flash host port sequencer
// assumes nfc_flash_model on the far side and the bound checker
`timescale 1ns/1ps

module tb_nfc_host;
    logic clk_i = 0;
    logic reset_n_i = 0;
    nfc_pkg::nfc_req_t req_i = '0;
    logic req_valid_i = 0;
    logic write_prot_n_i = 1;
    logic rd_ready_i = 0;
    logic stuck = 0;
    logic req_ready_o, rd_valid_o, busy_timeout_o, prog_refused_o, oe_n, rb_n;
    logic [7:0] rd_data_o, port_o, bus;
    logic [3:0] prog_cnt;
    nfc_pkg::nfc_pins_t pins_o;
    int errors = 0;
    int samples_checked = 0;
    always #2.5 clk_i = ~clk_i;

    nfc_host #(.BUSY_MAX_CYC(200)) u_nfc_host (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .write_prot_n_i(write_prot_n_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .rd_ready_i(rd_ready_i), .busy_timeout_o(busy_timeout_o),
        .prog_refused_o(prog_refused_o), .pins_o(pins_o), .shared_byte_port_i(bus),
        .shared_byte_port_o(port_o), .shared_byte_port_oe_n_o(oe_n), .ready_busy_n_i(rb_n));
    nfc_flash_model u_nfc_flash_model (.pins_i(pins_o), .host_d_i(port_o),
        .host_oe_n_i(oe_n), .stuck_i(stuck), .bus_o(bus), .ready_busy_n_o(rb_n),
        .prog_cnt_o(prog_cnt));

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // a wait that runs out ends the run as a mismatch
    task automatic bound(int n);
        if (n >= 400) begin
            check("wait bound", 8'h01, 8'h00);
            print_verdict();
        end
    endtask
    // ************************************************************
    // user side transfers
    // ************************************************************
    task automatic put(nfc_pkg::nfc_op_t op, logic [7:0] d);
        int n = 0;
        logic rdy;
        // one idle edge first, so valid never drops and rises in one step
        @(posedge clk_i);
        #1 req_i = '{op: op, data: d};
        req_valid_i = 1;
        do begin
            @(negedge clk_i) rdy = req_ready_o;
            @(posedge clk_i);
            n++;
        end while (rdy !== 1'b1 && n < 400);
        #1 req_valid_i = 0;
        bound(n);
    endtask
    task automatic get(logic [7:0] exp);
        int n = 0;
        @(posedge clk_i);
        #1;
        while (rd_valid_o !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1 n++;
        end
        bound(n);
        check("rd_data_o", rd_data_o, exp);
        rd_ready_i = 1;
        @(posedge clk_i);
        #1 rd_ready_i = 0;
    endtask
    task automatic open_page(logic [7:0] cmd, logic [7:0] col);
        put(nfc_pkg::NFC_OP_CMD, cmd);
        put(nfc_pkg::NFC_OP_ADDR, col);
        put(nfc_pkg::NFC_OP_ADDR, 8'h00);
        put(nfc_pkg::NFC_OP_ADDR, 8'h03);
        put(nfc_pkg::NFC_OP_ADDR, 8'h00);
    endtask
    task automatic load(logic [7:0] col);
        open_page(8'h00, col);
        put(nfc_pkg::NFC_OP_CMD, 8'h30);
        put(nfc_pkg::NFC_OP_WAIT, 8'h00);
    endtask
    task automatic refuse(logic [3:0] cnt);
        int n = 0;
        put(nfc_pkg::NFC_OP_CMD, 8'h10);
        while (prog_refused_o !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1 n++;
        end
        check("prog_refused_o", {7'h00, prog_refused_o}, 8'h01);
        check("prog_cnt", {4'h0, prog_cnt}, {4'h0, cnt});
    endtask
    // two reads with the user stalled: the buffer must refuse a third
    task automatic s_read_stall();
        load(8'hFE);
        put(nfc_pkg::NFC_OP_RDATA, 8'h00);
        put(nfc_pkg::NFC_OP_RDATA, 8'h00);
        req_i.op = nfc_pkg::NFC_OP_RDATA;
        repeat (40) @(posedge clk_i);
        #1 check("req_ready_o", {7'h00, req_ready_o}, 8'h00);
        get(8'hFE ^ 8'hA5);
        get(8'hFF ^ 8'hA5);
    endtask
    // program, read back, then a confirm under write protect
    task automatic s_program();
        open_page(8'h80, 8'h10);
        put(nfc_pkg::NFC_OP_WDATA, 8'h3C);
        put(nfc_pkg::NFC_OP_WDATA, 8'hC3);
        put(nfc_pkg::NFC_OP_CMD, 8'h10);
        put(nfc_pkg::NFC_OP_WAIT, 8'h00);
        check("prog_cnt", {4'h0, prog_cnt}, 8'h01);
        load(8'h10);
        put(nfc_pkg::NFC_OP_RDATA, 8'h00);
        get(8'h3C);
        write_prot_n_i = 0;
        refuse(4'h1);
        write_prot_n_i = 1;
    endtask
    // fill the partial program limit, the next confirm is refused
    task automatic s_partial();
        for (int i = 0; i < 3; i++) begin
            put(nfc_pkg::NFC_OP_CMD, 8'h10);
            put(nfc_pkg::NFC_OP_WAIT, 8'h00);
        end
        refuse(4'h4);
        // an erase confirm clears the limit and is never refused by it
        put(nfc_pkg::NFC_OP_CMD, 8'hD0);
        check("prog_refused_o", {7'h00, prog_refused_o}, 8'h00);
        put(nfc_pkg::NFC_OP_CMD, 8'h10);
        put(nfc_pkg::NFC_OP_WAIT, 8'h00);
        check("prog_cnt", {4'h0, prog_cnt}, 8'h05);
    endtask
    // device stuck busy: the wait must give up and flag it
    task automatic s_stuck();
        int n = 0;
        stuck = 1;
        put(nfc_pkg::NFC_OP_WAIT, 8'h00);
        while (busy_timeout_o !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1 n++;
        end
        check("busy_timeout_o", {7'h00, busy_timeout_o}, 8'h01);
        stuck = 0;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        #1 reset_n_i = 1;
        s_read_stall();
        s_program();
        s_partial();
        s_stuck();
        print_verdict();
    end
endmodule // tb_nfc_host
